// ### core/mwip_pkg.sv
// Package: register map, field positions, reset values, shared types.
// Assumes a 50 MHz AHB-Lite clock; all users import the whole package.
package mwip_pkg;

  // Register byte offsets
  localparam logic [11:0] MWIP_CTL_OFF = 12'h000;
  localparam logic [11:0] MWIP_HOLD_OFF = 12'h004;
  localparam logic [11:0] MWIP_TRC_OFF = 12'h008;
  localparam logic [11:0] MWIP_STAT_OFF = 12'h00C;

  // Address windows inside the 16 KB config space
  localparam logic [1:0] MWIP_WIN_WRAP = 2'h0;
  localparam logic [1:0] MWIP_WIN_RAM = 2'h1;
  localparam logic [1:0] MWIP_WIN_MAC = 2'h2;
  localparam logic [1:0] MWIP_WIN_MDIO = 2'h3;

  // Control register fields
  localparam int MWIP_CTL_GATE_BIT = 0;
  localparam int MWIP_CTL_MACRST_BIT = 1;
  localparam int MWIP_CTL_MDIORST_BIT = 2;

  // Transfer request control fields
  localparam int MWIP_TRC_PRI_LSB = 0;
  localparam int MWIP_TRC_PRI_W = 3;
  localparam int MWIP_TRC_DEPTH_LSB = 4;
  localparam int MWIP_TRC_DEPTH_W = 3;

  // Reset values
  localparam logic [2:0] MWIP_CTL_RST = 3'h0;
  localparam logic [16:0] MWIP_HOLD_RST = 17'h00000;
  localparam logic [2:0] MWIP_TRC_PRI_RST = 3'h1;
  localparam logic [2:0] MWIP_TRC_DEPTH_RST = 3'h3;

  // Holdoff counter width and tick divide
  localparam int MWIP_HOLD_W = 17;
  localparam logic [1:0] MWIP_TICK_DIV_LAST = 2'h3;

  // Descriptor memory: 4 KB, 16-byte descriptors
  localparam int MWIP_RAM_BYTES = 4096;
  localparam int MWIP_DESC_BYTES = 16;
  localparam int MWIP_DESC_COUNT = MWIP_RAM_BYTES / MWIP_DESC_BYTES;
  localparam int MWIP_RAM_WORDS = MWIP_RAM_BYTES / 4;
  localparam int MWIP_RAM_AW = 10;

  typedef enum logic [1:0] {
    MWIP_OWN_NONE,
    MWIP_OWN_HOST,
    MWIP_OWN_MAC
  } mwip_owner_t;

endpackage : mwip_pkg

// ### core/mwip_desc_ram.sv
// Descriptor memory: 1024 words of 32 bits, one port, registered read.
// Assumes the caller serialises host and MAC accesses onto the one port.
`timescale 1ns/1ps
module mwip_desc_ram
  import mwip_pkg::*;
(
  input wire logic hclk,
  input wire logic en,
  input wire logic we,
  input wire logic [MWIP_RAM_AW-1:0] addr,
  input wire logic [31:0] wdata,
  output logic [31:0] rdata
);

  logic [31:0] mem [MWIP_RAM_WORDS];

  always_ff @(posedge hclk) begin
    if (en) begin
      if (we) begin
        mem[addr] <= wdata;
      end
      rdata <= mem[addr];
    end
  end

endmodule : mwip_desc_ram

// ### core/mwip_top.sv
// Wrapper around a MAC and management unit: interrupt pacing, descriptor
// memory, arbitration and register decode. Assumes an AHB-Lite master,
// MAC and management blocks on the same hclk, and a host-side transfer port.
//
// Contract
// - Merge MAC and management interrupts into one host interrupt line.
// - Global gate bit in control register; cleared gate holds output low.
// - Re-setting gate with an irq input pending raises output, a fresh edge; it drops pending completion events.
// - Holdoff counter counts after re-enable; output stays low until zero.
// - At zero the holdoff adds no delay to interrupts.
// - Holdoff ticks at hclk/4, resets to zero, holds up to 17 bits.
// - Local 4 KB descriptor memory reachable by host and MAC.
// - Descriptors are 16 bytes; memory holds 256 descriptors.
// - Arbiter grants descriptor memory to host or MAC, one at a time.
// - Arbiter chooses receive or transmit DMA for the transfer port.
// - Config space maps wrapper, MAC and management registers.
// - Transfer control register sets request priority and queue depth.
// - Control register resets MAC alone or management unit alone.
// - Everything runs synchronously on one peripheral clock.
// - MAC raises an interrupt condition on each transfer completion.
`timescale 1ns/1ps
module mwip_top
  import mwip_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [13:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic mac_irq,
  input wire logic mdio_irq,
  input wire logic mac_txdone,
  input wire logic mac_rxdone,
  output logic host_irq,
  output logic mac_rst,
  output logic mdio_rst,
  output logic [2:0] xfer_priority,
  output logic [2:0] xfer_depth,
  output logic mac_sel,
  output logic mdio_sel,
  output logic [11:0] sub_addr,
  output logic sub_write,
  output logic [31:0] sub_wdata,
  input wire logic [31:0] mac_rdata,
  input wire logic [31:0] mdio_rdata,
  input wire logic mdma_req,
  input wire logic mdma_we,
  input wire logic [MWIP_RAM_AW-1:0] mdma_addr,
  input wire logic [31:0] mdma_wdata,
  output logic mdma_ack,
  output logic [31:0] mdma_rdata,
  input wire logic rx_dma_req,
  input wire logic tx_dma_req,
  output logic rx_dma_gnt,
  output logic tx_dma_gnt,
  input wire logic xfer_done
);

  // Bus data phase kinds
  typedef enum logic [2:0] {
    MWIP_PH_IDLE,
    MWIP_PH_REG,
    MWIP_PH_RAMW,
    MWIP_PH_RAMR,
    MWIP_PH_RAMD,
    MWIP_PH_SUB
  } mwip_phase_t;

  typedef struct packed {
    mwip_phase_t phase;
    logic [13:0] addr;
    logic write;
    logic gate;
    logic gate_d;
    logic mac_rst;
    logic mdio_rst;
    logic [16:0] hold_val;
    logic [16:0] hold_cnt;
    logic [1:0] tick;
    logic [2:0] pri;
    logic [2:0] depth;
    logic evt_pend;
    logic irq;
    logic [31:0] rdata;
    logic ready;
    logic mac_ack;
    logic [31:0] mac_rd;
    logic mac_rd_pend;
    logic last_host;
    logic rx_gnt;
    logic tx_gnt;
    logic last_rx;
    logic sub_sel_mac;
    logic sub_sel_mdio;
    logic [11:0] sub_addr;
    logic sub_write;
    logic [31:0] sub_wdata;
  } mwip_state_t;

  mwip_state_t st_reg;
  mwip_state_t st_next;

  logic ram_en;
  logic ram_we;
  logic [MWIP_RAM_AW-1:0] ram_addr;
  logic [31:0] ram_wdata;
  logic [31:0] ram_rdata;

  function automatic logic [1:0] win_of(input logic [13:0] a);
    return a[13:12];
  endfunction : win_of

  mwip_desc_ram u_ram (
    .hclk(hclk),
    .en(ram_en),
    .we(ram_we),
    .addr(ram_addr),
    .wdata(ram_wdata),
    .rdata(ram_rdata)
  );

  logic addr_phase;
  logic host_ram_req;
  logic mac_win;
  logic pending;
  assign addr_phase = hsel && hready && htrans[1];

  always_comb begin
    st_next = st_reg;
    ram_en = 1'b0;
    ram_we = 1'b0;
    ram_addr = '0;
    ram_wdata = '0;
    st_next.mac_ack = 1'b0;
    st_next.sub_sel_mac = 1'b0;
    st_next.sub_sel_mdio = 1'b0;
    // Data phase completion
    host_ram_req = 1'b0;
    unique case (st_reg.phase)
      MWIP_PH_IDLE, MWIP_PH_SUB: begin
      end
      MWIP_PH_REG: begin
        if (st_reg.write) begin
          unique case (st_reg.addr[11:0])
            MWIP_CTL_OFF: begin
              st_next.gate = hwdata[MWIP_CTL_GATE_BIT];
              st_next.mac_rst = hwdata[MWIP_CTL_MACRST_BIT];
              st_next.mdio_rst = hwdata[MWIP_CTL_MDIORST_BIT];
            end
            MWIP_HOLD_OFF: st_next.hold_val = hwdata[16:0];
            MWIP_TRC_OFF: begin
              st_next.pri = hwdata[MWIP_TRC_PRI_LSB +: MWIP_TRC_PRI_W];
              st_next.depth = hwdata[MWIP_TRC_DEPTH_LSB +: MWIP_TRC_DEPTH_W];
            end
            default: begin
            end
          endcase
        end
      end
      MWIP_PH_RAMW: begin
        host_ram_req = 1'b1;
      end
      MWIP_PH_RAMR: begin
        host_ram_req = 1'b1;
      end
      MWIP_PH_RAMD: begin
        st_next.rdata = ram_rdata;
        st_next.ready = 1'b1;
        st_next.phase = MWIP_PH_IDLE;
      end
      default: st_next.phase = MWIP_PH_IDLE;
    endcase
    if (st_reg.phase == MWIP_PH_SUB) begin
      st_next.rdata = st_reg.addr[13] && st_reg.addr[12] ? mdio_rdata : mac_rdata;
    end
    // one owner of the memory port per cycle
    mac_win = mdma_req && !st_reg.mac_ack && (!host_ram_req || st_reg.last_host);
    if (mac_win) begin
      ram_en = 1'b1;
      ram_we = mdma_we;
      ram_addr = mdma_addr;
      ram_wdata = mdma_wdata;
      st_next.mac_ack = 1'b1;
      st_next.last_host = 1'b0;
    end else if (host_ram_req) begin
      ram_en = 1'b1;
      ram_we = st_reg.write;
      ram_addr = st_reg.addr[11:2];
      ram_wdata = hwdata;
      st_next.last_host = 1'b1;
      st_next.phase = st_reg.write ? MWIP_PH_IDLE : MWIP_PH_RAMD;
      st_next.ready = st_reg.write;
    end
    st_next.mac_rd_pend = mac_win && !mdma_we;
    if (st_reg.mac_rd_pend) begin
      st_next.mac_rd = ram_rdata;
    end
    // Leave data phase for plain kinds
    if (st_reg.phase == MWIP_PH_REG || st_reg.phase == MWIP_PH_SUB) begin
      st_next.phase = MWIP_PH_IDLE;
      st_next.ready = 1'b1;
    end
    // New address phase
    if (addr_phase) begin
      st_next.addr = haddr;
      st_next.write = hwrite;
      st_next.ready = 1'b0;
      unique case (win_of(haddr))
        MWIP_WIN_WRAP: begin
          st_next.phase = MWIP_PH_REG;
          st_next.rdata = '0;
          unique case (haddr[11:0])
            MWIP_CTL_OFF: st_next.rdata = {29'h0, st_reg.mdio_rst, st_reg.mac_rst, st_reg.gate};
            MWIP_HOLD_OFF: st_next.rdata = {15'h0, st_reg.hold_val};
            MWIP_TRC_OFF: st_next.rdata = {25'h0, st_reg.depth, 1'b0, st_reg.pri};
            MWIP_STAT_OFF: st_next.rdata = {14'h0, st_reg.hold_cnt, st_reg.evt_pend};
            default: st_next.rdata = '0;
          endcase
        end
        MWIP_WIN_RAM: st_next.phase = hwrite ? MWIP_PH_RAMW : MWIP_PH_RAMR;
        MWIP_WIN_MAC, MWIP_WIN_MDIO: begin
          st_next.phase = MWIP_PH_SUB;
          st_next.sub_sel_mac = win_of(haddr) == MWIP_WIN_MAC;
          st_next.sub_sel_mdio = win_of(haddr) == MWIP_WIN_MDIO;
          st_next.sub_addr = haddr[11:0];
          st_next.sub_write = hwrite;
        end
      endcase
    end
    if (st_reg.phase == MWIP_PH_SUB && st_reg.write) begin
      st_next.sub_wdata = hwdata;
      st_next.sub_write = 1'b1;
    end
    // completion events stick until the gate is set again
    if (mac_txdone || mac_rxdone) begin
      st_next.evt_pend = 1'b1;
    end else if (!st_reg.gate && st_next.gate) begin
      st_next.evt_pend = 1'b0;
    end
    st_next.tick = st_reg.tick + 2'h1;
    st_next.gate_d = st_reg.gate;
    // reload on gate rise, count down and stop
    if (st_reg.gate && !st_reg.gate_d) begin
      st_next.hold_cnt = st_reg.hold_val;
      st_next.tick = '0;
    end else if (st_reg.hold_cnt != '0 && st_reg.tick == MWIP_TICK_DIV_LAST) begin
      st_next.hold_cnt = st_reg.hold_cnt - 17'h00001;
    end
    pending = mac_irq || mdio_irq || st_reg.evt_pend;
    st_next.irq = pending && st_reg.gate && st_reg.gate_d && st_reg.hold_cnt == '0;
    // DMA master choice, round robin, held until done
    if (st_reg.rx_gnt || st_reg.tx_gnt) begin
      if (xfer_done) begin
        st_next.rx_gnt = 1'b0;
        st_next.tx_gnt = 1'b0;
      end
    end else if (rx_dma_req && (!tx_dma_req || !st_reg.last_rx)) begin
      st_next.rx_gnt = 1'b1;
      st_next.last_rx = 1'b1;
    end else if (tx_dma_req) begin
      st_next.tx_gnt = 1'b1;
      st_next.last_rx = 1'b0;
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      st_reg <= '0;
      st_reg.ready <= 1'b1;
      st_reg.mac_rst <= MWIP_CTL_RST[MWIP_CTL_MACRST_BIT];
      st_reg.mdio_rst <= MWIP_CTL_RST[MWIP_CTL_MDIORST_BIT];
      st_reg.hold_val <= MWIP_HOLD_RST;
      st_reg.pri <= MWIP_TRC_PRI_RST;
      st_reg.depth <= MWIP_TRC_DEPTH_RST;
    end else begin
      st_reg <= st_next;
    end
  end

  assign hrdata = st_reg.rdata;
  assign hreadyout = st_reg.ready;
  assign hresp = 1'b0;
  assign host_irq = st_reg.irq;
  assign mac_rst = st_reg.mac_rst;
  assign mdio_rst = st_reg.mdio_rst;
  assign xfer_priority = st_reg.pri;
  assign xfer_depth = st_reg.depth;
  assign mac_sel = st_reg.sub_sel_mac;
  assign mdio_sel = st_reg.sub_sel_mdio;
  assign sub_addr = st_reg.sub_addr;
  assign sub_write = st_reg.sub_write;
  assign sub_wdata = st_reg.sub_wdata;
  assign mdma_ack = st_reg.mac_ack;
  assign mdma_rdata = st_reg.mac_rd;
  assign rx_dma_gnt = st_reg.rx_gnt;
  assign tx_dma_gnt = st_reg.tx_gnt;

endmodule : mwip_top

// ### test/mwip_top_asserts.sv
// Checker: bus answer, gate, reset bits, grants and descriptor port.
// Assumes one hclk domain; bound onto mwip_top by port name.
`timescale 1ns/1ps
module mwip_top_asserts
  import mwip_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic hsel,
  input wire logic [13:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic host_irq,
  input wire logic mac_rst,
  input wire logic mdio_rst,
  input wire logic mdma_req,
  input wire logic mdma_ack,
  input wire logic rx_dma_gnt,
  input wire logic tx_dma_gnt,
  input wire logic xfer_done
);
  logic wr_q;
  logic [2:0] ctl_q;
  default clocking cb @(posedge hclk);
  endclocking
  default disable iff (!hresetn);
  // Shadow of the control register
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      wr_q <= 1'b0;
      ctl_q <= MWIP_CTL_RST;
    end else begin
      wr_q <= hsel && hready && htrans[1] && hwrite && haddr == 14'h0000;
      if (wr_q) begin
        ctl_q <= hwdata[2:0];
      end
    end
  end
  sequence taken_s;
    hsel && hready && htrans[1];
  endsequence
  sequence back_s;
    !hreadyout ##[1:20] hreadyout;
  endsequence
  bus_answer_a: assert property (taken_s |=> back_s)
    else $error("bus transfer not answered");
  resp_okay_a: assert property (hresp == 1'b0)
    else $error("response not okay");
  gate_hold_a: assert property (host_irq |-> $past(ctl_q[0]))
    else $error("interrupt with gate cleared");
  fresh_edge_a: assert property ($rose(ctl_q[0]) |-> !host_irq [*2])
    else $error("no low before re-enabled interrupt");
  rst_bits_a: assert property (hreadyout |-> {mdio_rst, mac_rst} == ctl_q[2:1])
    else $error("module resets differ from control");
  one_grant_a: assert property (!(rx_dma_gnt && tx_dma_gnt))
    else $error("both transfer grants high");
  grant_hold_a: assert property ((rx_dma_gnt || tx_dma_gnt) && !xfer_done
    |=> $stable({rx_dma_gnt, tx_dma_gnt}))
    else $error("grant changed before done");
  ack_cause_a: assert property (mdma_ack |-> $past(mdma_req))
    else $error("descriptor ack without request");
endmodule : mwip_top_asserts

bind mwip_top mwip_top_asserts mwip_top_asserts_i (.*);

// ### test/mwip_far_model.sv
// Far side: MAC and management read data, MAC descriptor port, transfer port.
// Assumes hclk and the top module's handshakes; go starts one MAC read.
`timescale 1ns/1ps
module mwip_far_model
  import mwip_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic mac_sel,
  input wire logic mdio_sel,
  input wire logic rx_dma_gnt,
  input wire logic tx_dma_gnt,
  input wire logic mdma_ack,
  input wire logic [31:0] mdma_rdata,
  input wire logic go,
  output logic [31:0] mac_rdata,
  output logic [31:0] mdio_rdata,
  output logic xfer_done,
  output logic mdma_req,
  output logic [31:0] got
);
  localparam logic [31:0] MAC_PAT = 32'h5A0FC3E1;
  localparam logic [31:0] MDIO_PAT = 32'h0000BEEF;
  logic sel_q;
  logic msel_q;
  logic ack_q;
  logic [1:0] cnt;
  // Window data, inverted when not selected
  assign mac_rdata = (mac_sel || sel_q) ? MAC_PAT : ~MAC_PAT;
  assign mdio_rdata = (mdio_sel || msel_q) ? MDIO_PAT : ~MDIO_PAT;
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {sel_q, msel_q, ack_q, cnt, xfer_done, mdma_req} <= '0;
      got <= '0;
    end else begin
      sel_q <= mac_sel;
      msel_q <= mdio_sel;
      ack_q <= mdma_ack;
      // each transfer served in four cycles
      cnt <= ((rx_dma_gnt || tx_dma_gnt) && !xfer_done) ? cnt + 2'h1 : 2'h0;
      xfer_done <= cnt == 2'h2;
      if (go) begin
        mdma_req <= 1'b1;
      end else if (mdma_ack) begin
        mdma_req <= 1'b0;
      end
      if (ack_q) begin
        got <= mdma_rdata;
      end
    end
  end
endmodule : mwip_far_model

// ### test/mwip_top_tb.sv
// Testbench: AHB-Lite master tasks, one task per scenario, verdict.
// Assumes mwip_top with its bound checker and the far-side model.
`timescale 1ns/1ps
module mwip_top_tb
  import mwip_pkg::*;
;
  logic hclk, hresetn, hsel, hwrite, go, hreadyout, hresp, host_irq;
  logic mac_irq, mdio_irq, mac_txdone, mac_rxdone, mac_rst, mdio_rst;
  logic mac_sel, mdio_sel, sub_write, mdma_req, mdma_ack, xfer_done;
  logic rx_dma_req, tx_dma_req, rx_dma_gnt, tx_dma_gnt;
  logic [13:0] haddr;
  logic [1:0] htrans;
  logic [2:0] xfer_priority, xfer_depth;
  logic [11:0] sub_addr;
  logic [31:0] hwdata, hrdata, mac_rdata, mdio_rdata, sub_wdata, mdma_rdata;
  logic [31:0] got, rd;
  int error_cnt, compares;
  mwip_top mwip_top_i (.hsize(3'h2), .hready(hreadyout), .mdma_we(1'b0),
    .mdma_addr(10'h3FF), .mdma_wdata(32'h0), .*);
  mwip_far_model mwip_far_model_i (.*);
  initial begin
    hclk = 1'b0;
    forever #10 hclk = ~hclk;
  end
  task automatic check(input string n, input logic [31:0] s, input logic [31:0] e);
    compares++;
    if (s !== e) begin
      error_cnt++;
      $display("FAIL %s exp %h seen %h", n, e, s);
    end
  endtask : check
  task automatic stop_test();
    if (error_cnt == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask : stop_test
  task automatic xfer(input logic w, input logic [13:0] a, input logic [31:0] d);
    hsel <= 1'b1;
    hwrite <= w;
    haddr <= a;
    htrans <= 2'h2;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    {hsel, htrans} <= 3'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask : xfer
  task automatic rdc(input logic [13:0] a, input logic [31:0] e, input string n);
    xfer(1'b0, a, 32'h0);
    check(n, rd, e);
  endtask : rdc
  task automatic wait_irq(input logic v, input int n, input string s);
    for (int i = 0; i < n && host_irq !== v; i++) @(posedge hclk);
    check(s, 32'(host_irq), 32'(v));
  endtask : wait_irq
  task automatic t_regs();
    rdc(14'h0008, 32'({MWIP_TRC_DEPTH_RST, 1'b0, MWIP_TRC_PRI_RST}), "trc");
    rdc(14'h0004, 32'h0, "hold");
    xfer(1'b1, 14'h0008, 32'h57);
    check("pri", 32'({xfer_depth, 1'b0, xfer_priority}), 32'h57);
    xfer(1'b1, 14'h0000, 32'h6);
    check("rst", 32'({mdio_rst, mac_rst}), 32'h3);
    xfer(1'b1, 14'h0000, 32'h2);
    check("rst", 32'({mdio_rst, mac_rst}), 32'h1);
    xfer(1'b1, 14'h0004, 32'hFFFFF);
    rdc(14'h0004, 32'h1FFFF, "holdmax");
    xfer(1'b1, 14'h0010, 32'hFFFF);
    rdc(14'h0010, 32'h0, "unmapped");
    rdc(14'h2000, mwip_far_model_i.MAC_PAT, "mac win");
    rdc(14'h3000, mwip_far_model_i.MDIO_PAT, "mdio win");
    xfer(1'b1, 14'h2010, 32'h1234ABCD);
    check("sub", sub_wdata ^ 32'(sub_addr), 32'h1234ABDD);
  endtask : t_regs
  task automatic t_irq();
    xfer(1'b1, 14'h0004, 32'h0);
    xfer(1'b1, 14'h0000, 32'h1);
    mac_irq <= 1'b1;
    wait_irq(1'b1, 4, "isolated");
    xfer(1'b1, 14'h0000, 32'h0);
    wait_irq(1'b0, 3, "gate off");
    xfer(1'b1, 14'h0004, 32'h8);
    xfer(1'b1, 14'h0000, 32'h1);
    repeat (28) @(posedge hclk);
    check("holdoff", 32'(host_irq), 32'h0);
    wait_irq(1'b1, 12, "reenable");
    mac_irq <= 1'b0;
    xfer(1'b1, 14'h0004, 32'h0);
    for (int k = 0; k < 3; k++) begin
      xfer(1'b1, 14'h0000, 32'h0);
      xfer(1'b1, 14'h0000, 32'h1);
      wait_irq(1'b0, 3, "idle");
      {mdio_irq, mac_rxdone, mac_txdone} <= 3'h1 << k;
      @(posedge hclk);
      {mac_rxdone, mac_txdone} <= 2'h0;
      wait_irq(1'b1, 4, "source");
      mdio_irq <= 1'b0;
    end
  endtask : t_irq
  task automatic t_ram();
    xfer(1'b1, 14'h1FF0, 32'hC0DE0255);
    xfer(1'b1, 14'h1FFC, 32'hD00DF00D);
    go <= 1'b1;
    fork
      rdc(14'h1FF0, 32'hC0DE0255, "ram host");
      begin
        @(posedge hclk);
        go <= 1'b0;
      end
    join
    for (int i = 0; i < 20 && mdma_req !== 1'b0; i++) @(posedge hclk);
    @(posedge hclk);
    check("ram mac", got, 32'hD00DF00D);
  endtask : t_ram
  task automatic t_dma();
    logic f;
    {rx_dma_req, tx_dma_req} <= 2'h3;
    for (int i = 0; i < 8 && {rx_dma_gnt, tx_dma_gnt} === 2'h0; i++) @(posedge hclk);
    f = rx_dma_gnt;
    check("gnt", 32'(rx_dma_gnt ^ tx_dma_gnt), 32'h1);
    for (int i = 0; i < 8 && xfer_done !== 1'b1; i++) @(posedge hclk);
    {rx_dma_req, tx_dma_req} <= {!f, f};
    for (int i = 0; i < 8 && {rx_dma_gnt, tx_dma_gnt} !== {!f, f}; i++) @(posedge hclk);
    check("gnt2", 32'({rx_dma_gnt, tx_dma_gnt}), 32'({!f, f}));
    for (int i = 0; i < 8 && xfer_done !== 1'b1; i++) @(posedge hclk);
    {rx_dma_req, tx_dma_req} <= 2'h0;
  endtask : t_dma
  initial begin
    {hsel, hwrite, go, htrans, haddr, hwdata} = '0;
    {mac_irq, mdio_irq, mac_txdone, mac_rxdone, rx_dma_req, tx_dma_req} = '0;
    error_cnt = 0;
    compares = 0;
    hresetn = 1'b0;
    repeat (10) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    t_regs();
    t_irq();
    t_ram();
    t_dma();
    stop_test();
  end
  initial begin
    #100000;
    error_cnt++;
    stop_test();
  end
endmodule : mwip_top_tb
